// >>> core/gdcfg_pkg.sv
package gdcfg_pkg;

    // request identifiers; the answer echoes them, with the acknowledge flag when accepted
    localparam logic [7:0] MSG_SET_PROT = 8'h01;
    localparam logic [7:0] MSG_GET_PROT = 8'h02;
    localparam logic [7:0] MSG_SET_DAC  = 8'h03;
    localparam logic [7:0] MSG_GET_DAC  = 8'h04;
    localparam logic [7:0] MSG_SET_CFG2 = 8'h07;
    localparam logic [7:0] MSG_GET_CFG2 = 8'h08;
    localparam logic [7:0] ACK_FLAG     = 8'h40;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    // driver_protection_config fields
    localparam int PULLUP_KEEP_BIT   = 6;
    localparam int SLEEP_SEL_BIT     = 5;
    localparam int NEUTRAL_SIM_BIT   = 4;
    localparam int EXT_UV_DIS_BIT    = 3;
    localparam int EXT_SC_DIS_BIT    = 2;
    localparam int EXT_OC_MSB        = 1;
    localparam int EXT_OC_LSB        = 0;

    // third configuration register fields
    localparam int DEAD_TIME_MSB     = 4;
    localparam int DEAD_TIME_LSB     = 2;
    localparam int BLANK_MSB         = 1;
    localparam int BLANK_LSB         = 0;

    // implemented-bit masks and power-on values
    localparam logic [7:0] PROT_MASK  = 8'h7F;
    localparam logic [7:0] DAC_MASK   = 8'hFF;
    localparam logic [7:0] CFG2_MASK  = 8'h1F;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [7:0] DAC_RESET  = 8'h40;
    localparam logic [7:0] CFG2_RESET = 8'h00;

    // timing
    localparam int CLK_MHZ       = 200;
    localparam int NS_PER_US     = 1000;
    localparam int DEAD_MAX_NS   = 2000;
    localparam int DEAD_STEP_NS  = 250;
    localparam int BLANK_MAX_NS  = 4000;
    localparam int CYC_W         = 10;

    function automatic logic [CYC_W-1:0] ns_to_cycles(input int ns);
        ns_to_cycles = CYC_W'(ns * CLK_MHZ / NS_PER_US);
    endfunction

    function automatic logic [CYC_W-1:0] dead_cycles(input logic [2:0] code);
        dead_cycles = ns_to_cycles(DEAD_MAX_NS - DEAD_STEP_NS * int'(code));
    endfunction

    function automatic logic [CYC_W-1:0] blank_cycles(input logic [1:0] code);
        blank_cycles = ns_to_cycles(BLANK_MAX_NS >> code);
    endfunction

endpackage

// >>> core/gdcfg_reg.sv
`timescale 1ns/1ps
`default_nettype none

module gdcfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data
);

    // unimplemented bits never store, so they read back as zero after a write and as their RESET_VAL bits after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= RESET_VAL;
        end else if (wr_en) begin
            rd_data <= wr_data & IMPL_MASK;
        end
    end

endmodule

`default_nettype wire

// >>> core/gdcfg_top.sv
`timescale 1ns/1ps
`default_nettype none

module gdcfg_top (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        chip_enable,
    input  wire logic                        req_valid,
    input  wire logic [7:0]                  req_id,
    input  wire logic [7:0]                  req_data,
    output logic                             resp_valid,
    output logic      [7:0]                  resp_code,
    output logic      [7:0]                  resp_data,
    output logic                             pullup_keep,
    output logic                             sleep_select,
    output logic                             neutral_sim_en,
    output logic                             ext_gate_uv_disable,
    output logic                             ext_short_detect_disable,
    output logic      [1:0]                  ext_overcurrent_threshold,
    output logic      [7:0]                  dac_reference_code,
    output logic      [2:0]                  dead_time_sel,
    output logic      [1:0]                  blanking_sel,
    output logic      [gdcfg_pkg::CYC_W-1:0] dead_time_cycles,
    output logic      [gdcfg_pkg::CYC_W-1:0] blanking_cycles,
    output logic                             standby_active,
    output logic                             sleep_active,
    output logic                             pullup_connect
);
    import gdcfg_pkg::*;

    logic       ce_meta_q;
    logic       ce_q;
    logic [7:0] prot_q;
    logic [7:0] dac_q;
    logic [7:0] cfg2_q;
    logic       wr0;
    logic       wr1;
    logic       wr2;
    logic       sleep_change_bad;
    logic       accept_d;
    logic [7:0] code_d;
    logic [7:0] data_d;

    // chip enable is a pin: two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ce_meta_q <= 1'b0;
            ce_q      <= 1'b0;
        end else begin
            ce_meta_q <= chip_enable;
            ce_q      <= ce_meta_q;
        end
    end

    // sleep select may only move while standing in standby
    assign sleep_change_bad = (req_data[SLEEP_SEL_BIT] != prot_q[SLEEP_SEL_BIT]) && !standby_active;

    always_comb begin
        accept_d = 1'b0;
        data_d   = ZERO_BYTE;
        unique case (req_id)
            MSG_SET_PROT: begin
                accept_d = !sleep_change_bad;
                data_d   = accept_d ? (req_data & PROT_MASK) : prot_q;
            end
            MSG_GET_PROT: begin
                accept_d = 1'b1;
                data_d   = prot_q & PROT_MASK;
            end
            MSG_SET_DAC: begin
                accept_d = 1'b1;
                data_d   = req_data;
            end
            MSG_GET_DAC: begin
                accept_d = 1'b1;
                data_d   = dac_q;
            end
            MSG_SET_CFG2: begin
                accept_d = 1'b1;
                data_d   = req_data & CFG2_MASK;
            end
            MSG_GET_CFG2: begin
                accept_d = 1'b1;
                data_d   = cfg2_q & CFG2_MASK;
            end
            default: begin
                accept_d = 1'b0;
                data_d   = ZERO_BYTE;
            end
        endcase
        code_d = accept_d ? (req_id | ACK_FLAG) : req_id;
    end

    // stores happen only alongside an acknowledged answer
    assign wr0 = req_valid && (req_id == MSG_SET_PROT) && accept_d;
    assign wr1 = req_valid && (req_id == MSG_SET_DAC) && accept_d;
    assign wr2 = req_valid && (req_id == MSG_SET_CFG2) && accept_d;

    gdcfg_reg #(.RESET_VAL(PROT_RESET), .IMPL_MASK(PROT_MASK)) u_prot (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr0),
        .wr_data (req_data),
        .rd_data (prot_q)
    );

    gdcfg_reg #(.RESET_VAL(DAC_RESET), .IMPL_MASK(DAC_MASK)) u_dac (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr1),
        .wr_data (req_data),
        .rd_data (dac_q)
    );

    gdcfg_reg #(.RESET_VAL(CFG2_RESET), .IMPL_MASK(CFG2_MASK)) u_cfg2 (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr2),
        .wr_data (req_data),
        .rd_data (cfg2_q)
    );

    // one answer per request, one cycle later
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_code  <= ZERO_BYTE;
            resp_data  <= ZERO_BYTE;
        end else begin
            resp_valid <= req_valid;
            if (req_valid) begin
                resp_code <= code_d;
                resp_data <= data_d;
            end
        end
    end

    assign pullup_keep               = prot_q[PULLUP_KEEP_BIT];
    assign sleep_select              = prot_q[SLEEP_SEL_BIT];
    assign neutral_sim_en            = prot_q[NEUTRAL_SIM_BIT];
    assign ext_gate_uv_disable       = prot_q[EXT_UV_DIS_BIT];
    assign ext_short_detect_disable  = prot_q[EXT_SC_DIS_BIT];
    assign ext_overcurrent_threshold = prot_q[EXT_OC_MSB:EXT_OC_LSB];
    assign dac_reference_code        = dac_q;
    assign dead_time_sel             = cfg2_q[DEAD_TIME_MSB:DEAD_TIME_LSB];
    assign blanking_sel              = cfg2_q[BLANK_MSB:BLANK_LSB];

    // decoded times and power state, registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dead_time_cycles <= dead_cycles(CFG2_RESET[DEAD_TIME_MSB:DEAD_TIME_LSB]);
            blanking_cycles  <= blank_cycles(CFG2_RESET[BLANK_MSB:BLANK_LSB]);
        end else begin
            dead_time_cycles <= dead_cycles(dead_time_sel);
            blanking_cycles  <= blank_cycles(blanking_sel);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            standby_active <= 1'b0;
            sleep_active   <= 1'b0;
            pullup_connect <= 1'b0;
        end else begin
            standby_active <= !ce_q && !sleep_select;
            sleep_active   <= !ce_q && sleep_select;
            pullup_connect <= ce_q || (pullup_keep && !sleep_select);
        end
    end

    // assertions
    sequence s_set2;
        req_valid && req_id == MSG_SET_CFG2;
    endsequence

    sequence s_get2;
        req_valid && req_id == MSG_GET_CFG2;
    endsequence

    property p_set2_ack;
        @(posedge clk) disable iff (rst) s_set2 |=> resp_valid && resp_code == (MSG_SET_CFG2 | ACK_FLAG);
    endproperty
    a_set2_ack: assert property (p_set2_ack) else $error("cfg2 write answer code wrong");

    property p_get2_data;
        @(posedge clk) disable iff (rst)
            s_get2 |=> resp_code == (MSG_GET_CFG2 | ACK_FLAG) && resp_data == $past(cfg2_q);
    endproperty
    a_get2_data: assert property (p_get2_data) else $error("cfg2 read answer wrong");

    property p_dead_time;
        @(posedge clk) disable iff (rst)
            s_set2 ##1 1'b1 |=> dead_time_cycles == dead_cycles($past(req_data[DEAD_TIME_MSB:DEAD_TIME_LSB], 2));
    endproperty
    a_dead_time: assert property (p_dead_time) else $error("dead time not following write");

    property p_reserved2;
        @(posedge clk) disable iff (rst) resp_valid && resp_code == (MSG_GET_CFG2 | ACK_FLAG) |-> resp_data[7:5] == 3'b000;
    endproperty
    a_reserved2: assert property (p_reserved2) else $error("cfg2 reserved bits not zero");

    property p_sleep_pullup;
        @(posedge clk) disable iff (rst) (!ce_q && sleep_select) [*2] |-> !pullup_connect;
    endproperty
    a_sleep_pullup: assert property (p_sleep_pullup) else $error("pull-up connected in sleep");

    property p_keep_pullup;
        @(posedge clk) disable iff (rst) (pullup_keep && !sleep_select) |=> pullup_connect;
    endproperty
    a_keep_pullup: assert property (p_keep_pullup) else $error("pull-up dropped while kept");

    property p_sleep_guard;
        @(posedge clk) disable iff (rst)
            req_valid && req_id == MSG_SET_PROT && req_data[SLEEP_SEL_BIT] != sleep_select && !standby_active
            |=> resp_code == MSG_SET_PROT && $stable(prot_q);
    endproperty
    a_sleep_guard: assert property (p_sleep_guard) else $error("sleep select changed outside standby");

    property p_bit7_zero;
        @(posedge clk) disable iff (rst) resp_valid && resp_code == (MSG_GET_PROT | ACK_FLAG) |-> !resp_data[7];
    endproperty
    a_bit7_zero: assert property (p_bit7_zero) else $error("protection bit 7 read as one");

    // every read of the dac reference returns what the register held when the request was taken
    sequence s_get_dac;
        req_valid && req_id == MSG_GET_DAC;
    endsequence

    property p_dac_get;
        @(posedge clk) disable iff (rst)
            s_get_dac |=> resp_valid && resp_code == (MSG_GET_DAC | ACK_FLAG) && resp_data == $past(dac_q);
    endproperty
    a_dac_get: assert property (p_dac_get) else $error("dac reference read-back wrong");

    property p_nak_stable;
        @(posedge clk) disable iff (rst) resp_valid && !resp_code[6] |-> $stable(prot_q) && $stable(dac_q) && $stable(cfg2_q);
    endproperty
    a_nak_stable: assert property (p_nak_stable) else $error("register changed on refused request");

endmodule

`default_nettype wire

// >>> sim/gdcfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module gdcfg_host_model (
    input  wire logic       clk,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_code,
    input  wire logic [7:0] resp_data,
    output var logic        req_valid,
    output var logic  [7:0] req_id,
    output var logic  [7:0] req_data
);
    initial begin
        req_valid = 1'b0;
        req_id    = 8'h00;
        req_data  = 8'h00;
    end

    // one request; the answer is looked for under a bound and its delay returned
    task automatic xfer(input logic [7:0] id, input logic [7:0] d, output logic [7:0] code,
                        output logic [7:0] data, output int lat);
        lat = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_id    <= id;
        req_data  <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        // idle lines carry no stale copy of the request
        req_id    <= ~id;
        req_data  <= ~d;
        #1;
        while (resp_valid !== 1'b1 && lat < 4) begin
            @(posedge clk);
            #1;
            lat++;
        end
        code = resp_code;
        data = resp_data;
    endtask
endmodule

`default_nettype wire

// >>> sim/gdcfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module gdcfg_top_tb;
    import gdcfg_pkg::*;
    localparam int T_NS = 5;
    logic clk, rst, chip_enable, req_valid, resp_valid, pullup_keep, sleep_select, neutral_sim_en;
    logic ext_gate_uv_disable, ext_short_detect_disable, standby_active, sleep_active, pullup_connect;
    logic [7:0] req_id, req_data, resp_code, resp_data, dac_reference_code, v;
    logic [1:0] ext_overcurrent_threshold, blanking_sel;
    logic [2:0] dead_time_sel;
    logic [CYC_W-1:0] dead_time_cycles, blanking_cycles;
    logic [7:0] c0v [4] = '{8'hC0, 8'h09, 8'h16, 8'h1F};
    logic [7:0] dv [3] = '{8'hFF, 8'h00, 8'hA5};
    int miscompares = 0;
    int n_compared = 0;

    gdcfg_top dut (.clk(clk), .rst(rst), .chip_enable(chip_enable), .req_valid(req_valid), .req_id(req_id),
        .req_data(req_data), .resp_valid(resp_valid), .resp_code(resp_code), .resp_data(resp_data),
        .pullup_keep(pullup_keep), .sleep_select(sleep_select), .neutral_sim_en(neutral_sim_en),
        .ext_gate_uv_disable(ext_gate_uv_disable), .ext_short_detect_disable(ext_short_detect_disable),
        .ext_overcurrent_threshold(ext_overcurrent_threshold), .dac_reference_code(dac_reference_code),
        .dead_time_sel(dead_time_sel), .blanking_sel(blanking_sel), .dead_time_cycles(dead_time_cycles),
        .blanking_cycles(blanking_cycles), .standby_active(standby_active), .sleep_active(sleep_active),
        .pullup_connect(pullup_connect));

    gdcfg_host_model host (.clk(clk), .resp_valid(resp_valid), .resp_code(resp_code), .resp_data(resp_data),
        .req_valid(req_valid), .req_id(req_id), .req_data(req_data));

    always #2.5 clk = ~clk;

    function automatic logic [CYC_W-1:0] dt_exp(input int code);
        return CYC_W'((2000 - 250 * code) / T_NS);
    endfunction

    function automatic logic [CYC_W-1:0] bl_exp(input int code);
        return CYC_W'((4000 >> code) / T_NS);
    endfunction

    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic txn(input logic [7:0] id, input logic [7:0] d, input logic [7:0] ec, input logic [7:0] ed);
        logic [7:0] c;
        logic [7:0] r;
        int lat;
        host.xfer(id, d, c, r, lat);
        `CHK("latency", 0, lat)
        `CHK("resp_code", ec, c)
        `CHK("resp_data", ed, r)
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        `CHK("dead_cycles", dt_exp(0), dead_time_cycles)
        `CHK("blank_cycles", bl_exp(0), blanking_cycles)
        txn(MSG_GET_PROT, 8'h00, 8'h42, 8'h00);
        txn(MSG_GET_DAC, 8'h00, 8'h44, 8'h40);
        txn(MSG_GET_CFG2, 8'h00, 8'h48, 8'h00);
        $display("test reset done");
    endtask

    initial begin
        #100000;
        miscompares++;
        summarize();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        chip_enable = 1'b1;
        do_reset();
        for (int dt = 0; dt < 8; dt++) begin
            for (int bl = 0; bl < 4; bl++) begin
                v = {3'b111, 3'(dt), 2'(bl)};
                txn(MSG_SET_CFG2, v, 8'h47, v & 8'h1F);
                `CHK("dead_sel", 3'(dt), dead_time_sel)
                `CHK("blank_sel", 2'(bl), blanking_sel)
                @(posedge clk);
                #1;
                `CHK("dead_cycles", dt_exp(dt), dead_time_cycles)
                `CHK("blank_cycles", bl_exp(bl), blanking_cycles)
                txn(MSG_GET_CFG2, 8'h00, 8'h48, v & 8'h1F);
            end
        end
        $display("test timing fields done");
        foreach (dv[i]) begin
            txn(MSG_SET_DAC, dv[i], 8'h43, dv[i]);
            `CHK("dac", dv[i], dac_reference_code)
            txn(MSG_GET_DAC, 8'h00, 8'h44, dv[i]);
        end
        txn(8'h05, 8'h00, 8'h05, 8'h00);
        `CHK("dac_kept", dv[2], dac_reference_code)
        $display("test dac done");
        @(posedge clk);
        chip_enable <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            v = c0v[i] & 8'h7F;
            txn(MSG_SET_PROT, c0v[i], 8'h41, v);
            txn(MSG_GET_PROT, 8'h00, 8'h42, v);
            `CHK("driver_protection_config_outs", v[6:0], {pullup_keep, sleep_select, neutral_sim_en, ext_gate_uv_disable,
                ext_short_detect_disable, ext_overcurrent_threshold})
            `CHK("pullup_connect", v[6], pullup_connect)
            `CHK("standby", 1'b1, standby_active)
        end
        $display("test protection fields done");
        txn(MSG_SET_PROT, 8'h60, 8'h41, 8'h60);
        repeat (3) @(posedge clk);
        #1;
        `CHK("sleep_active", 1'b1, sleep_active)
        `CHK("pullup_connect", 1'b0, pullup_connect)
        txn(MSG_SET_PROT, 8'h40, 8'h01, 8'h60);
        @(posedge clk);
        chip_enable <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("pullup_connect", 1'b1, pullup_connect)
        txn(MSG_SET_PROT, 8'h00, 8'h01, 8'h60);
        txn(MSG_SET_PROT, 8'h7F, 8'h41, 8'h7F);
        $display("test sleep select done");
        do_reset();
        summarize();
    end
endmodule

`default_nettype wire
